// [cisd_params.svh]
// Constants for the compact instruction expander: field positions, opcodes and encodings
`ifndef CISD_PARAMS_SVH
`define CISD_PARAMS_SVH

// Compact instruction field positions
`define CISD_TOP_MSB                 15
`define CISD_TOP_LSB                 13
`define CISD_OP_MSB                  12
`define CISD_OP_LSB                  11
`define CISD_AMT_MSB                 10
`define CISD_AMT_LSB                 6
`define CISD_SRC_MSB                 5
`define CISD_SRC_LSB                 3
`define CISD_DST_MSB                 2
`define CISD_DST_LSB                 0
`define CISD_IMM_BIT                 10
`define CISD_SUB_BIT                 9
`define CISD_RN_MSB                  8
`define CISD_RN_LSB                  6

// Top-field and opcode values
`define CISD_TOP_SHIFT               3'h0
`define CISD_OP_SHIFT_LEFT_LOGICAL   2'h0
`define CISD_OP_SHIFT_RIGHT_LOGICAL  2'h1
`define CISD_OP_SHIFT_RIGHT_ARITH    2'h2
`define CISD_OP_ADDSUB               2'h3

// Full-set encoding pieces: always condition, S bit set
`define CISD_COND_AL                 4'hE
`define CISD_DP_MOV                  4'hD
`define CISD_DP_ADD                  4'h4
`define CISD_DP_SUB                  4'h2
`define CISD_SH_SHIFT_LEFT_LOGICAL   2'h0
`define CISD_SH_SHIFT_RIGHT_LOGICAL  2'h1
`define CISD_SH_SHIFT_RIGHT_ARITH    2'h2

// Reset value of the expanded word: a plain no-op move
`define CISD_NOP_WORD                32'hE1A00000

`endif

// [cisd_pkg.sv]
// Types shared by the compact instruction expander
package cisd_pkg;

    // Decoded compact format class
    typedef enum logic [1:0] {
        CISD_FMT_SHIFT,
        CISD_FMT_ADDSUB,
        CISD_FMT_OTHER
    } cisd_fmt_e;

    // Register number in the full set
    typedef logic [3:0] cisd_reg_t;

endpackage

// [cisd_decoder.sv]
// Compact instruction expander for the shift and add/subtract formats
`timescale 1ns/1ps
`include "cisd_params.svh"

// What this block does
// (RQ1) Expand 16-bit compact words into 32-bit instructions
// (RQ2) Opcode 00 shifts source left by immediate
// (RQ3) Opcode 01 logical right shift by immediate
// (RQ4) Opcode 10 arithmetic right shift, sign kept
// (RQ5) Shift format reaches low registers only
// (RQ6) Shift format always updates condition flags
// (RQ7) Same cycles as the full-set equivalent
// (RQ8) Flag update per mnemonic, not for branches/memory
// (RQ9) Add keeps flags in formats 5, 12, 13
// (RQ10) Move keeps flags in high-register format
// (RQ11) Add/subtract low register or 3-bit immediate
// (RQ12) Immediate bit selects operand; opcode bit selects sub
// (RQ13) Low registers 0-7, high registers 8-15
// (RQ14) Shifts: carry gets last bit out, overflow kept
// (RQ15) Opcode 11 goes to the add/subtract decoder
module cisd_decoder
    import cisd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Compact instruction from fetch
    input  wire logic        cmp_valid,
    input  wire logic [15:0] cmp_instr,
    // Expanded instruction to execute
    output logic             exp_valid,
    output logic [31:0]      exp_instr,
    output logic             exp_sets_flags,
    output logic             exp_shift_carry,
    output logic             exp_keep_carry,
    output logic             exp_keep_ovf,
    output logic             exp_known
);

    // Field extraction from the compact word; every field is read every cycle
    // and only qualified later by the request valid
    wire [2:0]       top_f             = cmp_instr[`CISD_TOP_MSB:`CISD_TOP_LSB];    // Format group
    wire [1:0]       op_f              = cmp_instr[`CISD_OP_MSB:`CISD_OP_LSB];      // Shift kind, or 11
    wire [4:0]       shift_amount_imm  = cmp_instr[`CISD_AMT_MSB:`CISD_AMT_LSB];    // Shift distance
    wire [2:0]       small_add_imm     = cmp_instr[`CISD_RN_MSB:`CISD_RN_LSB];      // Immediate operand
    wire [2:0]       rn_f              = cmp_instr[`CISD_RN_MSB:`CISD_RN_LSB];      // Second register operand
    wire             imm_sel           = cmp_instr[`CISD_IMM_BIT];                  // Immediate, not register
    wire             sub_sel           = cmp_instr[`CISD_SUB_BIT];                  // Subtract, not add

    // Low-register fields widened with a zero top bit, so 8-15 cannot be named.
    // The compact fields hold only three bits; the zero top bit is what keeps
    // the high register group out of reach of these formats.
    wire cisd_reg_t  src_low_reg       = {1'b0, cmp_instr[`CISD_SRC_MSB:`CISD_SRC_LSB]};   // [RQ5] [RQ13]
    wire cisd_reg_t  dst_low_reg       = {1'b0, cmp_instr[`CISD_DST_MSB:`CISD_DST_LSB]};   // [RQ5] [RQ13]
    wire cisd_reg_t  rn_low_reg        = {1'b0, rn_f};                                     // [RQ13]

    // Format class; opcode 11 in the shift position falls through to
    // add/subtract, because both formats share the same top field
    wire             in_group0         = (top_f == `CISD_TOP_SHIFT);                // Shift or add/subtract
    wire             is_addsub         = in_group0 && (op_f == `CISD_OP_ADDSUB);    // [RQ15]
    wire             is_shift          = in_group0 && !is_addsub;                   // [RQ2] [RQ3] [RQ4]
    wire cisd_fmt_e  fmt               = is_shift ? CISD_FMT_SHIFT :
                                         (is_addsub ? CISD_FMT_ADDSUB : CISD_FMT_OTHER);

    // Shifter type field of the full-set move, one code per compact opcode
    wire [1:0]       sh_type           =
        (op_f == `CISD_OP_SHIFT_LEFT_LOGICAL)  ? `CISD_SH_SHIFT_LEFT_LOGICAL  :    // [RQ2]
        (op_f == `CISD_OP_SHIFT_RIGHT_LOGICAL) ? `CISD_SH_SHIFT_RIGHT_LOGICAL :    // [RQ3]
                                                 `CISD_SH_SHIFT_RIGHT_ARITH;       // [RQ4]

    // Carry handling for execute. A left shift by zero is a plain move and
    // keeps carry. Right shifts with a zero field mean a distance of 32, so
    // bit 31 still leaves the register and becomes the carry.
    wire             zero_amt          = (shift_amount_imm == 5'h00);               // Zero distance field
    wire             keep_c            = is_shift && zero_amt &&
                                         (op_f == `CISD_OP_SHIFT_LEFT_LOGICAL);     // [RQ14]
    wire             carry_out         = is_shift && !keep_c;                       // [RQ14]

    // Move-with-flags, shifted by immediate: destination = source shifted.
    // The S bit is always set, as for the flag-setting full-set move.
    wire [31:0]      shift_word        = {`CISD_COND_AL, 2'h0, 1'b0, `CISD_DP_MOV, 1'b1,
                                          4'h0, dst_low_reg, shift_amount_imm, sh_type,
                                          1'b0, src_low_reg};                       // [RQ2] [RQ3] [RQ4] [RQ6] [RQ10]

    // Add/subtract with flags; the immediate form carries the 3-bit value
    wire [3:0]       dp_op             = sub_sel ? `CISD_DP_SUB : `CISD_DP_ADD;     // [RQ12]
    wire [11:0]      op2_field         = imm_sel ? {9'h000, small_add_imm}
                                                 : {8'h00, rn_low_reg};             // [RQ11] [RQ12]
    wire [31:0]      addsub_word       = {`CISD_COND_AL, 2'h0, imm_sel, dp_op, 1'b1,
                                          src_low_reg, dst_low_reg, op2_field};     // [RQ11] [RQ9]

    // Next values of the output registers. Other formats pass a no-op and
    // are reported unknown, so execute never acts on a half-built word.
    // Both decoded formats always update the condition flags.
    wire [31:0]      exp_instr_d       = (fmt == CISD_FMT_SHIFT)  ? shift_word  :
                                         (fmt == CISD_FMT_ADDSUB) ? addsub_word :
                                                                    `CISD_NOP_WORD; // [RQ1]
    wire             exp_valid_d       = cmp_valid;                                 // [RQ7]
    wire             exp_known_d       = cmp_valid && (fmt != CISD_FMT_OTHER);      // Decoded here
    wire             exp_sets_flags_d  = cmp_valid && (is_shift || is_addsub);      // [RQ6] [RQ8] [RQ9] [RQ10]
    wire             exp_shift_carry_d = cmp_valid && carry_out;                    // [RQ14]
    wire             exp_keep_carry_d  = cmp_valid && keep_c;                       // [RQ14]
    wire             exp_keep_ovf_d    = cmp_valid && is_shift;                     // [RQ14]

    // Output registers; every output leaves straight from one of these.
    // One register stage only, one expanded word per compact word, and no
    // stall, so execution cycles are those of the full-set word.
    logic            exp_valid_q;        // Word expanded last cycle
    logic [31:0]     exp_instr_q;        // Expanded full-set word
    logic            exp_sets_flags_q;   // Word updates condition flags
    logic            exp_shift_carry_q;  // Carry takes the last bit out
    logic            exp_keep_carry_q;   // Carry left as it was
    logic            exp_keep_ovf_q;     // Overflow left as it was
    logic            exp_known_q;        // Word was a decoded format

    // Valid bit: one answer per compact word, one cycle later
    // No back-pressure exists, so it simply follows the request
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_valid_q <= 1'b0;                        // Nothing pending
        end
        else
        begin
            exp_valid_q <= exp_valid_d;                 // [RQ7]
        end
    end

    // Expanded word; loaded every cycle, qualified by the valid bit
    // Reset shows a harmless no-op rather than an all-zero word
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_instr_q <= `CISD_NOP_WORD;              // Safe no-op
        end
        else
        begin
            exp_instr_q <= exp_instr_d;                 // [RQ1]
        end
    end

    // Flag-update record for execute
    // Low whenever no valid word was taken
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_sets_flags_q <= 1'b0;                   // No update
        end
        else
        begin
            exp_sets_flags_q <= exp_sets_flags_d;       // [RQ6] [RQ8]
        end
    end

    // Carry from the last bit shifted out
    // Set for every shift except a left shift by zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_shift_carry_q <= 1'b0;                  // No shift
        end
        else
        begin
            exp_shift_carry_q <= exp_shift_carry_d;     // [RQ14]
        end
    end

    // Carry kept: left shift by zero moves the value unchanged
    // Exclusive with the shifted-carry flag for shift words
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_keep_carry_q <= 1'b0;                   // No shift
        end
        else
        begin
            exp_keep_carry_q <= exp_keep_carry_d;       // [RQ14]
        end
    end

    // Overflow kept: shifts never touch the overflow flag
    // Add/subtract words leave overflow to the adder
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_keep_ovf_q <= 1'b0;                     // No shift
        end
        else
        begin
            exp_keep_ovf_q <= exp_keep_ovf_d;           // [RQ14]
        end
    end

    // Known bit: word was one of the formats built here
    // Other formats arrive as a no-op with this bit low
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exp_known_q <= 1'b0;                        // Nothing decoded
        end
        else
        begin
            exp_known_q <= exp_known_d;                 // [RQ1]
        end
    end

    // Outputs driven straight from the registers
    assign exp_valid       = exp_valid_q;
    assign exp_instr       = exp_instr_q;
    assign exp_sets_flags  = exp_sets_flags_q;
    assign exp_shift_carry = exp_shift_carry_q;
    assign exp_keep_carry  = exp_keep_carry_q;
    assign exp_keep_ovf    = exp_keep_ovf_q;
    assign exp_known       = exp_known_q;

endmodule

// [cisd_properties.sv]
// Concurrent checks on the compact instruction expander ports
`timescale 1ns/1ps
`include "cisd_params.svh"
module cisd_properties
(
    // Clock, reset and request
    input wire logic        clk, nrst, cmp_valid,
    input wire logic [15:0] cmp_instr,
    // Expanded outputs
    input wire logic        exp_valid, exp_sets_flags, exp_shift_carry, exp_keep_carry, exp_keep_ovf, exp_known,
    input wire logic [31:0] exp_instr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shift form and add/subtract form requests
    wire sh = cmp_valid && cmp_instr[15:13] == 3'h0 && cmp_instr[12:11] != 2'h3;
    wire ad = cmp_valid && cmp_instr[15:11] == 5'h03;
    a_valid_follows: assert property (cmp_valid |=> exp_valid) else $error("no answer");
    a_no_spurious: assert property (!cmp_valid |=> !exp_valid) else $error("stray answer");
    a_shift_word: assert property (sh |=> exp_instr == {12'hE1B, 5'h0, $past(cmp_instr[2:0]),
        $past(cmp_instr[10:6]), $past(cmp_instr[12:11]), 2'h0, $past(cmp_instr[5:3])}) else $error("bad shift");
    a_shift_flags: assert property (sh |=> exp_sets_flags && exp_keep_ovf && exp_known) else $error("flags");
    a_shift_carry: assert property (sh && cmp_instr[12:6] != 7'h0 |=> exp_shift_carry && !exp_keep_carry)
        else $error("carry");
    a_lsl_zero: assert property (sh && cmp_instr[12:6] == 7'h0 |=> exp_keep_carry) else $error("keep");
    a_addsub_word: assert property (ad |=> exp_instr[31:20] == {6'h38, $past(cmp_instr[10]), 1'b0,
        !$past(cmp_instr[9]), $past(cmp_instr[9]), 2'h1} && exp_known && exp_sets_flags && !exp_keep_ovf
        && !exp_shift_carry && !exp_keep_carry) else $error("bad add/sub");
    a_other_nop: assert property (cmp_valid && cmp_instr[15:13] != 3'h0 |=> !exp_known && !exp_sets_flags
        && exp_instr == `CISD_NOP_WORD) else $error("not a no-op");
    // Main scenarios
    c_shift: cover property (sh);
    c_addsub: cover property (ad);
    c_other: cover property (cmp_valid && cmp_instr[15:13] != 3'h0);
endmodule
bind cisd_decoder cisd_properties i_cisd_properties (.clk, .nrst, .cmp_valid, .cmp_instr, .exp_valid, .exp_instr,
    .exp_sets_flags, .exp_shift_carry, .exp_keep_carry, .exp_keep_ovf, .exp_known);

// [cisd_fetch_model.sv]
// Fetch-stage model presenting compact words
`timescale 1ns/1ps
module cisd_fetch_model
(
    // Request from the bench
    input wire logic        go,
    input wire logic [15:0] word,
    // Fetch outputs
    output logic            cmp_valid,
    output logic [15:0]     cmp_instr
);
    // Idle word is junk, so show the inverse
    assign cmp_valid = go;
    assign cmp_instr = go ? word : ~word;
endmodule

// [testbench.sv]
// Self-checking bench for the compact instruction expander
`timescale 1ns/1ps
`include "cisd_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench;
    logic        clk = 0, nrst = 0, go = 0, cmp_valid, exp_valid, sets, scar, kcar, kovf, known;
    logic [15:0] word = 16'h0000, cmp_instr;
    logic [31:0] exp_instr;
    int          n_fail = 0, n_compared = 0;
    cisd_fetch_model i_cisd_fetch_model (.go, .word, .cmp_valid, .cmp_instr);
    cisd_decoder i_cisd_decoder (.clk, .nrst, .cmp_valid, .cmp_instr, .exp_valid, .exp_instr, .exp_sets_flags(sets),
        .exp_shift_carry(scar), .exp_keep_carry(kcar), .exp_keep_ovf(kovf), .exp_known(known));
    // Clock, 4 ns period
    initial forever #2 clk = ~clk;
    // Present one word, return with its answer settled
    task automatic issue(input logic [15:0] w);
        @(posedge clk) #1 go = 1;
        word = w;
        @(posedge clk) #1 go = 0;
        `CHK(exp_valid, 1'b1)
    endtask
    // Three shift kinds at amounts 0, 31 and 11
    task automatic t_shift;
        for (int k = 0; k < 9; k++)
        begin
            logic [1:0] op = 2'(k / 3);
            logic [4:0] amt = (k % 3 == 0) ? 5'h00 : ((k % 3 == 1) ? 5'h1F : 5'h0B);
            logic [2:0] rs = 3'(k + 5), rd = 3'(k);
            issue({3'h0, op, amt, rs, rd});
            `CHK(exp_instr, {12'hE1B, 5'h0, rd, amt, op, 2'h0, rs})
            `CHK({sets, kovf, known}, 3'h7)
            `CHK(scar, !(op == 2'h0 && amt == 5'h0))
            `CHK(kcar, op == 2'h0 && amt == 5'h0)
        end
    endtask
    // Register and immediate add and subtract
    task automatic t_addsub;
        for (int m = 0; m < 4; m++)
        begin
            issue({5'h03, 2'(m), 3'h6, 3'h2, 3'h1});
            `CHK(exp_instr, {6'h38, m[1], 1'b0, !m[0], m[0], 2'h1, 8'h21, 9'h0, 3'h6})
            `CHK({sets, known}, 2'h3)
            `CHK({scar, kcar, kovf}, 3'h0)
        end
    endtask
    // Uncovered format yields the no-op word
    task automatic t_other;
        issue(16'h2000);
        `CHK({known, sets, exp_instr}, {2'h0, `CISD_NOP_WORD})
        `CHK({scar, kcar, kovf}, 3'h0)
    endtask
    // Counts and verdict
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        #1 `CHK({exp_valid, exp_instr}, {1'b0, `CISD_NOP_WORD})
        nrst = 1;
        t_shift;
        t_addsub;
        t_other;
        complete_run;
    end
    // Watchdog
    initial
    begin
        #4000 n_fail++;
        complete_run;
    end
endmodule
